// [hdl/sxch_pkg.sv]
// shared types and constants for the extended command handler
package sxch_pkg;

    // decoded command codes from the sdi-12 line parser
    typedef enum logic [3:0] {
        SXCH_OP_GET_COEF = 4'h0,
        SXCH_OP_SET_COEF = 4'h1,
        SXCH_OP_GET_PEAK = 4'h2,
        SXCH_OP_SET_PEAK = 4'h3,
        SXCH_OP_GET_WAVE = 4'h4,
        SXCH_OP_SET_WAVE = 4'h5,
        SXCH_OP_GET_SUPP = 4'h6,
        SXCH_OP_SET_SUPP = 4'h7,
        SXCH_OP_SAVE_BKG = 4'h8,
        SXCH_OP_WAKE = 4'h9,
        SXCH_OP_RECAL = 4'hA,
        SXCH_OP_FACTORY = 4'hB,
        SXCH_OP_GET_FCAL = 4'hC,
        SXCH_OP_SET_FCAL = 4'hD,
        SXCH_OP_MEASURE = 4'hE,
        SXCH_OP_STANDARD = 4'hF
    } sxch_op_e;

    // reply value format: plain integer or signed q16.16
    typedef enum logic {
        SXCH_FMT_INT = 1'b0,
        SXCH_FMT_FIX = 1'b1
    } sxch_fmt_e;

    typedef struct packed {
        logic [7:0] addr;
        sxch_op_e op;
        logic signed [31:0] param;
    } sxch_cmd_s;

    // serializer appends cr lf after value
    typedef struct packed {
        logic [7:0] addr;
        sxch_fmt_e fmt;
        logic signed [31:0] value;
    } sxch_rsp_s;

    typedef struct packed {
        logic signed [31:0] coef;
        logic peak_last;
        logic [11:0] wave_len;
        logic [1:0] suppress;
        logic forced_cal;
    } sxch_cfg_s;

    localparam logic signed [31:0] SXCH_COEF_RST = 32'sh0000_8000;
    localparam logic [11:0] SXCH_WAVE_RST = 12'h000;
    localparam logic [11:0] SXCH_WAVE_MAX = 12'hE10;
    localparam logic [1:0] SXCH_SUPP_MAX = 2'h3;
    localparam logic signed [31:0] SXCH_ACK_ZERO = 32'sh0000_0000;
    localparam logic signed [31:0] SXCH_ACK_ONE = 32'sh0000_0001;

    localparam longint SXCH_CLK_HZ = 50_000_000;
    localparam longint SXCH_WAKE_S = 60;
    localparam longint SXCH_WAKE_CYC = SXCH_WAKE_S * SXCH_CLK_HZ;

endpackage

// [hdl/sxch_handler.sv]
// extended command handler: settings, background, wake window, recalibration
`timescale 1ns/10ps

// Notes on behaviour
// - get coefficient replies address plus current signed smoothing coefficient.
// - peak select is 0 strongest or 1 farthest; get and set reply code.
// - wave analysis length readable and writable, 0 up to 3600.
// - two-bit suppression: 1 drops wave, 2 drops angle, 3 drops both.
// - save background records echo curve to distance; weaker echoes ignored.
// - save background with distance zero clears stored reference instead.
// - background distance taken in currently selected level unit.
// - in sdi-12 mode sleep until measure command; other ports ignored asleep.
// - wake replies address plus zero, then stays active for sixty seconds.
// - host connection opened in wake window keeps device active while present.
// - recalibrate replies one, clears calibration, reruns and stores it.
// - factory default replies one and restores defaults; operator cycles power.
// - forced continuous calibration switch, 0 off, 1 on, readable, writable.
// - every other mandated sdi-12 command is passed to the standard handler.
module sxch_handler #(
    parameter longint WAKE_CYC = sxch_pkg::SXCH_WAKE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // decoded commands from the sdi-12 parser
    input wire logic cmd_valid,
    input wire sxch_pkg::sxch_cmd_s cmd,
    // reply to the sdi-12 serializer
    output sxch_pkg::sxch_rsp_s rsp,
    output logic rsp_valid,
    // other mandated commands forwarded
    output sxch_pkg::sxch_cmd_s std_cmd,
    output logic std_valid,
    // power management
    input wire logic sdi12_mode,
    input wire logic host_connected,
    input wire logic measure_done,
    output logic asleep,
    output logic serial_ports_en,
    // processing settings
    input wire logic [2:0] level_unit,
    output sxch_pkg::sxch_cfg_s cfg,
    // background reference
    output logic bkg_save,
    output logic bkg_clear,
    output logic bkg_valid,
    output logic signed [31:0] bkg_range,
    output logic [2:0] bkg_unit,
    // calibration and factory restore
    output logic recal_start,
    output logic factory_restore
);
    import sxch_pkg::*;

    typedef enum logic [3:0] {
        ST_AWAKE = 4'b0001,
        ST_SLEEP = 4'b0010,
        ST_WINDOW = 4'b0100,
        ST_HOST = 4'b1000
    } sxch_pwr_e;

    localparam logic [31:0] WAKE_LAST = 32'(WAKE_CYC - 1);

    sxch_pwr_e pwr, next_pwr;
    logic [31:0] win_cnt, next_win_cnt;
    sxch_cfg_s next_cfg;
    sxch_rsp_s next_rsp;
    sxch_cmd_s next_std_cmd;
    logic next_rsp_valid, next_std_valid;
    logic next_bkg_save, next_bkg_clear, next_bkg_valid;
    logic signed [31:0] next_bkg_range;
    logic [2:0] next_bkg_unit;
    logic next_recal_start, next_factory_restore;
    logic next_asleep, next_serial_ports_en;

    // settings, replies and one-shot actions
    always_comb begin
        next_cfg = cfg;
        next_rsp = rsp;
        next_rsp_valid = 1'b0;
        next_std_cmd = std_cmd;
        next_std_valid = 1'b0;
        next_bkg_save = 1'b0;
        next_bkg_clear = 1'b0;
        next_bkg_valid = bkg_valid;
        next_bkg_range = bkg_range;
        next_bkg_unit = bkg_unit;
        next_recal_start = 1'b0;
        next_factory_restore = 1'b0;
        if (cmd_valid) begin
            next_rsp.addr = cmd.addr;
            next_rsp.fmt = SXCH_FMT_INT;
            next_rsp_valid = 1'b1;
            unique case (cmd.op)
                // range advisory only, any value kept
                SXCH_OP_SET_COEF: begin
                    next_cfg.coef = cmd.param;
                    next_rsp.fmt = SXCH_FMT_FIX;
                    next_rsp.value = cmd.param;
                end
                SXCH_OP_GET_COEF: begin
                    next_rsp.fmt = SXCH_FMT_FIX;
                    next_rsp.value = cfg.coef;
                end
                SXCH_OP_SET_PEAK: begin
                    if (cmd.param == 32'sh0000_0000 || cmd.param == 32'sh0000_0001) begin
                        next_cfg.peak_last = cmd.param[0];
                    end
                    next_rsp.value = {31'h0000_0000, next_cfg.peak_last};
                end
                SXCH_OP_GET_PEAK: next_rsp.value = {31'h0000_0000, cfg.peak_last};
                SXCH_OP_SET_WAVE: begin
                    if (cmd.param >= 0 && cmd.param <= $signed({20'h0_0000, SXCH_WAVE_MAX})) begin
                        next_cfg.wave_len = cmd.param[11:0];
                    end
                    next_rsp.value = {20'h0_0000, next_cfg.wave_len};
                end
                SXCH_OP_GET_WAVE: next_rsp.value = {20'h0_0000, cfg.wave_len};
                SXCH_OP_SET_SUPP: begin
                    if (cmd.param >= 0 && cmd.param <= $signed({30'h0000_0000, SXCH_SUPP_MAX})) begin
                        next_cfg.suppress = cmd.param[1:0];
                    end
                    next_rsp.value = {30'h0000_0000, next_cfg.suppress};
                end
                SXCH_OP_GET_SUPP: next_rsp.value = {30'h0000_0000, cfg.suppress};
                SXCH_OP_SET_FCAL: begin
                    if (cmd.param == 32'sh0000_0000 || cmd.param == 32'sh0000_0001) begin
                        next_cfg.forced_cal = cmd.param[0];
                    end
                    next_rsp.value = {31'h0000_0000, next_cfg.forced_cal};
                end
                SXCH_OP_GET_FCAL: next_rsp.value = {31'h0000_0000, cfg.forced_cal};
                SXCH_OP_SAVE_BKG: begin
                    next_rsp.value = cmd.param;
                    if (cmd.param == 32'sh0000_0000) begin
                        next_bkg_clear = 1'b1;
                        next_bkg_valid = 1'b0;
                    end else begin
                        next_bkg_save = 1'b1;
                        next_bkg_valid = 1'b1;
                        next_bkg_range = cmd.param;
                        next_bkg_unit = level_unit;
                    end
                end
                SXCH_OP_WAKE: next_rsp.value = SXCH_ACK_ZERO;
                SXCH_OP_RECAL: begin
                    next_rsp.value = SXCH_ACK_ONE;
                    next_recal_start = 1'b1;
                end
                SXCH_OP_FACTORY: begin
                    next_rsp.value = SXCH_ACK_ONE;
                    next_factory_restore = 1'b1;
                    next_cfg.coef = SXCH_COEF_RST;
                    next_cfg.peak_last = 1'b0;
                    next_cfg.wave_len = SXCH_WAVE_RST;
                    next_cfg.suppress = 2'h0;
                    next_cfg.forced_cal = 1'b0;
                    next_bkg_valid = 1'b0;
                    next_bkg_clear = 1'b1;
                end
                SXCH_OP_MEASURE, SXCH_OP_STANDARD: begin
                    next_rsp_valid = 1'b0;
                    next_std_cmd = cmd;
                    next_std_valid = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= '{coef: SXCH_COEF_RST, peak_last: 1'b0, wave_len: SXCH_WAVE_RST,
                     suppress: 2'h0, forced_cal: 1'b0};
            rsp <= '{addr: 8'h00, fmt: SXCH_FMT_INT, value: 32'sh0000_0000};
            rsp_valid <= 1'b0;
            std_cmd <= '{addr: 8'h00, op: SXCH_OP_STANDARD, param: 32'sh0000_0000};
            std_valid <= 1'b0;
            bkg_save <= 1'b0;
            bkg_clear <= 1'b0;
            bkg_valid <= 1'b0;
            bkg_range <= 32'sh0000_0000;
            bkg_unit <= 3'h0;
            recal_start <= 1'b0;
            factory_restore <= 1'b0;
        end else begin
            cfg <= next_cfg;
            rsp <= next_rsp;
            rsp_valid <= next_rsp_valid;
            std_cmd <= next_std_cmd;
            std_valid <= next_std_valid;
            bkg_save <= next_bkg_save;
            bkg_clear <= next_bkg_clear;
            bkg_valid <= next_bkg_valid;
            bkg_range <= next_bkg_range;
            bkg_unit <= next_bkg_unit;
            recal_start <= next_recal_start;
            factory_restore <= next_factory_restore;
        end
    end

    // power management: sleep, measure, wake window, host hold
    always_comb begin
        next_pwr = pwr;
        next_win_cnt = win_cnt;
        unique case (pwr)
            ST_AWAKE: begin
                if (sdi12_mode && !host_connected) begin
                    next_pwr = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!sdi12_mode) begin
                    next_pwr = ST_AWAKE;
                end else if (cmd_valid && cmd.op == SXCH_OP_MEASURE) begin
                    next_pwr = ST_AWAKE;
                end else if (cmd_valid && cmd.op == SXCH_OP_WAKE) begin
                    next_pwr = ST_WINDOW;
                    next_win_cnt = 32'h0000_0000;
                end
            end
            ST_WINDOW: begin
                next_win_cnt = win_cnt + 32'h0000_0001;
                if (host_connected) begin
                    next_pwr = ST_HOST;
                end else if (!sdi12_mode) begin
                    next_pwr = ST_AWAKE;
                end else if (win_cnt >= WAKE_LAST) begin
                    next_pwr = ST_SLEEP;
                end
            end
            ST_HOST: begin
                if (!host_connected) begin
                    next_pwr = sdi12_mode ? ST_SLEEP : ST_AWAKE;
                end
            end
        endcase
        // a wake command in ST_AWAKE under sdi-12 mode opens a fresh window; inside a window it does not restart it
        if (pwr == ST_AWAKE && sdi12_mode && cmd_valid && cmd.op == SXCH_OP_WAKE) begin
            next_pwr = ST_WINDOW;
            next_win_cnt = 32'h0000_0000;
        end
        // in ST_AWAKE, measurement keeps the part up until the measure path reports done; a wake command still opens a window
        if (pwr == ST_AWAKE && sdi12_mode && !measure_done && !host_connected) begin
            next_pwr = (next_pwr == ST_WINDOW) ? ST_WINDOW : ST_AWAKE;
        end
        next_asleep = (next_pwr == ST_SLEEP);
        next_serial_ports_en = (next_pwr != ST_SLEEP);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr <= ST_AWAKE;
            win_cnt <= 32'h0000_0000;
            asleep <= 1'b0;
            serial_ports_en <= 1'b1;
        end else begin
            pwr <= next_pwr;
            win_cnt <= next_win_cnt;
            asleep <= next_asleep;
            serial_ports_en <= next_serial_ports_en;
        end
    end

endmodule // sxch_handler

// [verif/sxch_handler_monitor.sv]
// assertion checker bound to the extended command handler
`timescale 1ns/10ps
module sxch_handler_monitor
    import sxch_pkg::*;
#(
    parameter longint WAKE_CYC = 50
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // command and reply
    input wire logic cmd_valid,
    input wire sxch_pkg::sxch_cmd_s cmd,
    input wire sxch_pkg::sxch_rsp_s rsp,
    input wire logic rsp_valid,
    input wire logic std_valid,
    // power
    input wire logic asleep,
    input wire logic serial_ports_en,
    // settings and background
    input wire logic [2:0] level_unit,
    input wire sxch_pkg::sxch_cfg_s cfg,
    input wire logic bkg_save,
    input wire logic bkg_clear,
    input wire logic bkg_valid,
    input wire logic signed [31:0] bkg_range,
    input wire logic [2:0] bkg_unit,
    input wire logic recal_start,
    input wire logic factory_restore
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_peak;
        cmd_valid && cmd.op == SXCH_OP_SET_PEAK |=> rsp_valid && rsp.value == 32'(cfg.peak_last);
    endproperty
    a_peak: assert property (p_peak) else $error("peak echo wrong");
    property p_wave;
        cmd_valid && cmd.op == SXCH_OP_SET_WAVE && cmd.param > 32'sh0000_0E10
            |=> cfg.wave_len == $past(cfg.wave_len);
    endproperty
    a_wave: assert property (p_wave) else $error("wave length not kept");
    property p_supp;
        cmd_valid && cmd.op == SXCH_OP_SET_SUPP && cmd.param inside {[0:3]}
            |=> 32'(cfg.suppress) == $past(cmd.param);
    endproperty
    a_supp: assert property (p_supp) else $error("suppress not taken");
    property p_bsave;
        cmd_valid && cmd.op == SXCH_OP_SAVE_BKG && cmd.param != 0 |=> bkg_save && bkg_valid
            && bkg_range == $past(cmd.param) && bkg_unit == $past(level_unit);
    endproperty
    a_bsave: assert property (p_bsave) else $error("background save wrong");
    property p_bclr;
        cmd_valid && cmd.op == SXCH_OP_SAVE_BKG && cmd.param == 0 |=> bkg_clear && !bkg_valid;
    endproperty
    a_bclr: assert property (p_bclr) else $error("background clear wrong");
    property p_wake;
        cmd_valid && cmd.op == SXCH_OP_WAKE |=> rsp.value == SXCH_ACK_ZERO && !asleep;
    endproperty
    a_wake: assert property (p_wake) else $error("wake reply wrong");
    property p_recal;
        cmd_valid && cmd.op == SXCH_OP_RECAL |=> recal_start && rsp.value == SXCH_ACK_ONE;
    endproperty
    a_recal: assert property (p_recal) else $error("recal reply wrong");
    property p_fac;
        cmd_valid && cmd.op == SXCH_OP_FACTORY |=> factory_restore && bkg_clear && !bkg_valid
            && rsp.value == SXCH_ACK_ONE && cfg.coef == SXCH_COEF_RST
            && cfg.wave_len == SXCH_WAVE_RST;
    endproperty
    a_fac: assert property (p_fac) else $error("factory restore wrong");
    property p_std;
        cmd_valid && cmd.op inside {SXCH_OP_MEASURE, SXCH_OP_STANDARD} |=> std_valid && !rsp_valid;
    endproperty
    a_std: assert property (p_std) else $error("standard command not forwarded");
    property p_ports;
        asleep |-> !serial_ports_en;
    endproperty
    a_ports: assert property (p_ports) else $error("ports open while asleep");
endmodule // sxch_handler_monitor

bind sxch_handler sxch_handler_monitor #(.WAKE_CYC(WAKE_CYC)) i_mon (
    .clk(clk),
    .rst_n(rst_n),
    .cmd_valid(cmd_valid),
    .cmd(cmd),
    .rsp(rsp),
    .rsp_valid(rsp_valid),
    .std_valid(std_valid),
    .asleep(asleep),
    .serial_ports_en(serial_ports_en),
    .level_unit(level_unit),
    .cfg(cfg),
    .bkg_save(bkg_save),
    .bkg_clear(bkg_clear),
    .bkg_valid(bkg_valid),
    .bkg_range(bkg_range),
    .bkg_unit(bkg_unit),
    .recal_start(recal_start),
    .factory_restore(factory_restore)
);

// [verif/sxch_recorder.sv]
// behavioural sdi-12 recorder issuing decoded commands
`timescale 1ns/10ps
module sxch_recorder
    import sxch_pkg::*;
(
    // clock
    input wire logic clk,
    // command out, reply in
    output logic cmd_valid,
    output sxch_pkg::sxch_cmd_s cmd,
    input wire sxch_pkg::sxch_rsp_s rsp,
    input wire logic rsp_valid
);
    initial begin
        cmd_valid <= 1'b0;
        cmd <= '0;
    end

    task automatic xfer(input sxch_op_e op, input logic signed [31:0] p, output logic v,
                        output sxch_rsp_s r);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{addr: 8'h30, op: op, param: p};
        @(posedge clk);
        cmd_valid <= 1'b0;
        // stale fields would mask a decoder that ignores valid
        cmd <= ~cmd;
        // the reply pulse stands only in the cycle after the taking edge
        #1;
        v = rsp_valid;
        r = rsp;
    endtask
endmodule // sxch_recorder

// [verif/tb.sv]
// self-checking bench for the extended command handler
`timescale 1ns/10ps
module tb;
    import sxch_pkg::*;
    localparam int WT = 50;
    logic clk, rst_n, cmd_valid, rsp_valid, std_valid, sdi12_mode, host_connected, measure_done;
    logic asleep, serial_ports_en, bkg_save, bkg_clear, bkg_valid, recal_start, factory_restore;
    logic [2:0] level_unit, bkg_unit;
    logic signed [31:0] bkg_range;
    sxch_cmd_s cmd, std_cmd;
    sxch_rsp_s rsp;
    sxch_cfg_s cfg;
    int fail_count, check_count;
    logic v;
    sxch_rsp_s r;

    sxch_handler #(.WAKE_CYC(WT)) i_dut (
        .clk(clk),
        .rst_n(rst_n),
        .cmd_valid(cmd_valid),
        .cmd(cmd),
        .rsp(rsp),
        .rsp_valid(rsp_valid),
        .std_cmd(std_cmd),
        .std_valid(std_valid),
        .sdi12_mode(sdi12_mode),
        .host_connected(host_connected),
        .measure_done(measure_done),
        .asleep(asleep),
        .serial_ports_en(serial_ports_en),
        .level_unit(level_unit),
        .cfg(cfg),
        .bkg_save(bkg_save),
        .bkg_clear(bkg_clear),
        .bkg_valid(bkg_valid),
        .bkg_range(bkg_range),
        .bkg_unit(bkg_unit),
        .recal_start(recal_start),
        .factory_restore(factory_restore)
    );
    sxch_recorder i_rec (
        .clk(clk),
        .cmd_valid(cmd_valid),
        .cmd(cmd),
        .rsp(rsp),
        .rsp_valid(rsp_valid)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cc(input sxch_op_e op, input logic signed [31:0] p, input logic [31:0] e);
        sxch_fmt_e f;
        f = (op inside {SXCH_OP_GET_COEF, SXCH_OP_SET_COEF}) ? SXCH_FMT_FIX : SXCH_FMT_INT;
        i_rec.xfer(op, p, v, r);
        chk({v, r.addr, r.fmt, r.value}, {1'b1, 8'h30, f, e});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        sdi12_mode = 1'b0;
        host_connected = 1'b0;
        measure_done = 1'b1;
        level_unit = 3'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        settle(1);
        chk(cfg, {SXCH_COEF_RST, 1'b0, SXCH_WAVE_RST, 2'h0, 1'b0});
        cc(SXCH_OP_GET_COEF, 0, SXCH_COEF_RST);
        cc(SXCH_OP_SET_COEF, 32'sh0000_4000, 32'h0000_4000);
        cc(SXCH_OP_GET_COEF, 0, 32'h0000_4000);
        cc(SXCH_OP_SET_PEAK, 1, 1);
        cc(SXCH_OP_SET_PEAK, 2, 1);
        cc(SXCH_OP_GET_PEAK, 0, 1);
        cc(SXCH_OP_SET_PEAK, 0, 0);
        cc(SXCH_OP_SET_WAVE, 3600, 3600);
        cc(SXCH_OP_SET_WAVE, 3601, 3600);
        cc(SXCH_OP_GET_WAVE, 0, 3600);
        for (int i = 0; i < 4; i++) begin
            cc(SXCH_OP_SET_SUPP, i, i);
            cc(SXCH_OP_GET_SUPP, 0, i);
        end
        cc(SXCH_OP_SET_SUPP, 4, 3);
        cc(SXCH_OP_SET_FCAL, 1, 1);
        cc(SXCH_OP_SET_FCAL, 2, 1);
        cc(SXCH_OP_GET_FCAL, 0, 1);
        $display("settings test done");
        @(posedge clk);
        level_unit <= 3'h3;
        cc(SXCH_OP_SAVE_BKG, 5, 5);
        chk({bkg_valid, bkg_unit, bkg_range}, {1'b1, 3'h3, 32'h0000_0005});
        cc(SXCH_OP_SAVE_BKG, 0, 0);
        chk(bkg_valid, 1'b0);
        cc(SXCH_OP_RECAL, 0, 1);
        cc(SXCH_OP_FACTORY, 0, 1);
        chk(cfg, {SXCH_COEF_RST, 1'b0, SXCH_WAVE_RST, 2'h0, 1'b0});
        chk({factory_restore, bkg_clear}, 2'b11);
        $display("action test done");
        @(posedge clk);
        sdi12_mode <= 1'b1;
        settle(3);
        chk({asleep, serial_ports_en}, 2'b10);
        // a host session cannot open while asleep
        @(posedge clk);
        host_connected <= 1'b1;
        settle(3);
        chk({asleep, serial_ports_en}, 2'b10);
        @(posedge clk);
        host_connected <= 1'b0;
        cc(SXCH_OP_WAKE, 0, 0);
        settle(WT - 1);
        chk(asleep, 1'b0);
        settle(1);
        chk(asleep, 1'b1);
        cc(SXCH_OP_WAKE, 0, 0);
        @(posedge clk);
        host_connected <= 1'b1;
        settle(WT + 10);
        chk(asleep, 1'b0);
        @(posedge clk);
        host_connected <= 1'b0;
        settle(3);
        chk(asleep, 1'b1);
        @(posedge clk);
        measure_done <= 1'b0;
        i_rec.xfer(SXCH_OP_MEASURE, 0, v, r);
        chk({v, asleep}, 2'b00);
        chk({std_valid, std_cmd}, {1'b1, 8'h30, SXCH_OP_MEASURE, 32'h0000_0000});
        @(posedge clk);
        measure_done <= 1'b1;
        settle(3);
        chk(asleep, 1'b1);
        i_rec.xfer(SXCH_OP_STANDARD, 32'sh0000_0007, v, r);
        chk({v, asleep, std_valid, std_cmd.op}, {3'b011, SXCH_OP_STANDARD});
        $display("power test done");
        summarize();
    end

    initial begin
        #100us;
        fail_count++;
        summarize();
    end
endmodule // tb
